// *** core/tpt_timer.sv ***
// Decided for this implementation: the address-and-strobe port and the address map.
`timescale 1ns/1ps

module tpt_timer (
  // Clock and reset
  input  wire logic       clk_sys_i,
  input  wire logic       rst_n_i,
  // Register port
  input  wire logic [7:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  output logic      [7:0] rdata_o,
  // External event input, synchronous to clk_sys_i
  input  wire logic       ext_event_i,
  // General I/O side of the shared pin
  input  wire logic       gpio_out_i,
  input  wire logic       gpio_oe_i,
  // Shared output pin
  output logic            shared_output_pin_o,
  output logic            shared_output_pin_oe_o,
  output logic            pin_takeover_o,
  // Timer status
  output logic            tick_irq_flag_o,
  output logic            tick_irq_o
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Top count for the active mode; plain timer always runs 256
  function automatic logic [7:0] mod_mask(input tpt_pkg::tpt_mode_t m);
    logic [7:0] r;
    r = tpt_pkg::TPT_MASK_256;
    if (m.pwm_out_enable) begin
      unique case ({m.reload_enable, m.tone_out_enable})
        2'b00: r = tpt_pkg::TPT_MASK_256;
        2'b01: r = tpt_pkg::TPT_MASK_64;
        2'b10: r = tpt_pkg::TPT_MASK_32;
        2'b11: r = tpt_pkg::TPT_MASK_16;
      endcase
    end
    return r;
  endfunction : mod_mask

  // ----------------------------------------------------------------
  // Reset synchroniser
  // ----------------------------------------------------------------
  logic rst_q1_ff;
  logic rst_q2_ff;
  logic rst_n;

  // Async assert, release through two flops
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_q1_ff <= 1'b0;
      rst_q2_ff <= 1'b0;
    end else begin
      rst_q1_ff <= 1'b1;
      rst_q2_ff <= rst_q1_ff;
    end
  end
  assign rst_n = rst_q2_ff;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  tpt_pkg::tpt_req_t  req;
  tpt_pkg::tpt_mode_t mode_ff;
  logic [7:0]         count_ff;
  logic [7:0]         nxt_count;
  logic [7:0]         ref_stage_ff;
  logic [7:0]         ref_active_ff;
  logic [7:0]         nxt_ref_active;
  logic [7:0]         pre_cnt_ff;
  logic [7:0]         pre_mask;
  logic [7:0]         cnt_mask;
  logic               ext_q_ff;
  logic               tick;
  logic               ovf;
  logic               wr_mode;
  logic               wr_count;
  logic               wr_reload;
  logic               wr_irq;
  logic               irq_en_ff;
  logic               irq_flag_ff;
  logic               tone_ff;
  logic               pwm_ff;
  logic               tone_mode;
  logic               pwm_mode;
  logic               reload_active;
  logic [7:0]         rdata_ff;
  assign req = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};

  // Write decode
  assign wr_mode   = req.wr && (req.addr == tpt_pkg::TPT_OFS_MODE);
  assign wr_count  = req.wr && (req.addr == tpt_pkg::TPT_OFS_COUNT);
  assign wr_reload = req.wr && (req.addr == tpt_pkg::TPT_OFS_RELOAD);
  assign wr_irq    = req.wr && (req.addr == tpt_pkg::TPT_OFS_IRQ);

  // ----------------------------------------------------------------
  // Mode register
  // ----------------------------------------------------------------
  // Plain read/write register, zero at reset
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      mode_ff <= tpt_pkg::tpt_mode_t'(tpt_pkg::TPT_MODE_RST);
    end else if (wr_mode) begin
      mode_ff <= tpt_pkg::tpt_mode_t'(req.wdata);
    end
  end

  assign pwm_mode      = mode_ff.pwm_out_enable;
  // Tone only counts while PWM is off; the pwm_out_enable gate here keeps that so
  assign tone_mode     = mode_ff.tone_out_enable && !mode_ff.pwm_out_enable;
  assign reload_active = mode_ff.reload_enable || mode_ff.pwm_out_enable;
  assign cnt_mask      = mod_mask(mode_ff);

  // ----------------------------------------------------------------
  // Tick source
  // ----------------------------------------------------------------
  // Divisor is 256 >> rate; a tick lands when the low bits are all ones
  assign pre_mask = tpt_pkg::TPT_MASK_256 >> mode_ff.prescale_select;

  // Free-running prescaler, parked at zero while stopped
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      pre_cnt_ff <= tpt_pkg::TPT_COUNT_RST;
    end else if (!mode_ff.timer_run) begin
      pre_cnt_ff <= tpt_pkg::TPT_COUNT_RST;
    end else begin
      pre_cnt_ff <= pre_cnt_ff + 8'h01;
    end
  end

  // Event input history for rising-edge detection
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      ext_q_ff <= 1'b0;
    end else begin
      ext_q_ff <= ext_event_i;
    end
  end

  // Event mode ignores the rate field entirely
  always_comb begin
    if (mode_ff.clock_source_select) begin
      tick = mode_ff.timer_run && ext_event_i && !ext_q_ff;
    end else begin
      tick = mode_ff.timer_run && ((pre_cnt_ff & pre_mask) == pre_mask);
    end
  end

  // ----------------------------------------------------------------
  // Counter and reference buffers
  // ----------------------------------------------------------------
  // Overflow when the masked count sits at the top of the modulus
  assign ovf = tick && ((count_ff & cnt_mask) == cnt_mask);

  // Staged value moves to the active buffer only at overflow, so a
  // write mid-period never reshapes the period under way
  assign nxt_ref_active = ovf ? ref_stage_ff : ref_active_ff;

  // Next count: PWM wraps to zero, reload mode loads the new value
  always_comb begin
    nxt_count = count_ff;
    if (ovf) begin
      if (pwm_mode) begin
        nxt_count = 8'h00;
      end else if (reload_active) begin
        nxt_count = nxt_ref_active;
      end else begin
        nxt_count = 8'h00;
      end
    end else if (tick) begin
      nxt_count = count_ff + 8'h01;
    end
  end

  // Counter holds while run is clear; a software write wins
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      count_ff <= tpt_pkg::TPT_COUNT_RST;
    end else if (wr_count) begin
      count_ff <= req.wdata;
    end else begin
      count_ff <= nxt_count;
    end
  end

  // Staging buffer, write only from software
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      ref_stage_ff <= tpt_pkg::TPT_RELOAD_RST;
    end else if (wr_reload) begin
      ref_stage_ff <= req.wdata;
    end
  end

  // Active comparison / reload buffer
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      ref_active_ff <= tpt_pkg::TPT_RELOAD_RST;
    end else begin
      ref_active_ff <= nxt_ref_active;
    end
  end

  // ----------------------------------------------------------------
  // Overflow flag and its enable
  // ----------------------------------------------------------------
  // Overflow sets the flag in every mode; set wins over a clear
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      irq_flag_ff <= 1'b0;
    end else if (ovf) begin
      irq_flag_ff <= 1'b1;
    end else if (wr_irq) begin
      irq_flag_ff <= req.wdata[tpt_pkg::TPT_IRQ_FLAG_BIT];
    end
  end

  // Enable only gates the request line
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      irq_en_ff <= 1'b0;
    end else if (wr_irq) begin
      irq_en_ff <= req.wdata[tpt_pkg::TPT_IRQ_EN_BIT];
    end
  end

  assign tick_irq_flag_o = irq_flag_ff;
  assign tick_irq_o      = irq_flag_ff && irq_en_ff;

  // ----------------------------------------------------------------
  // Waveforms
  // ----------------------------------------------------------------
  // Tone: toggle per overflow, gives half the overflow rate
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      tone_ff <= 1'b0;
    end else if (!mode_ff.timer_run || !tone_mode) begin
      tone_ff <= 1'b0;
    end else if (ovf) begin
      tone_ff <= !tone_ff;
    end
  end

  // PWM: compare the coming count with the coming reference so the
  // wrap and the buffer swap land in the same edge; zero stays low
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      pwm_ff <= 1'b0;
    end else if (!mode_ff.timer_run || !pwm_mode) begin
      pwm_ff <= 1'b0;
    end else begin
      pwm_ff <= (nxt_count & cnt_mask) < (nxt_ref_active & cnt_mask);
    end
  end

  // ----------------------------------------------------------------
  // Shared pin
  // ----------------------------------------------------------------
  // Enabling either function takes the pin from general I/O
  always_comb begin
    pin_takeover_o = pwm_mode || tone_mode;
    if (pwm_mode) begin
      shared_output_pin_o    = pwm_ff;
      shared_output_pin_oe_o = 1'b1;
    end else if (tone_mode) begin
      shared_output_pin_o    = tone_ff;
      shared_output_pin_oe_o = 1'b1;
    end else begin
      shared_output_pin_o    = gpio_out_i;
      shared_output_pin_oe_o = gpio_oe_i;
    end
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  // Data one cycle after the strobe; reload buffer reads as zero
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      rdata_ff <= tpt_pkg::TPT_RDATA_NONE;
    end else if (req.rd) begin
      unique case (req.addr)
        tpt_pkg::TPT_OFS_MODE:  rdata_ff <= mode_ff;
        tpt_pkg::TPT_OFS_COUNT: rdata_ff <= count_ff;
        tpt_pkg::TPT_OFS_IRQ:   rdata_ff <= {6'h00, irq_flag_ff, irq_en_ff};
        default:                rdata_ff <= tpt_pkg::TPT_RDATA_NONE;
      endcase
    end else begin
      rdata_ff <= tpt_pkg::TPT_RDATA_NONE;
    end
  end
  assign rdata_o = rdata_ff;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n);

  chk_tone_toggle: assert property (
    (mode_ff.timer_run && tone_mode && ovf && !wr_mode) |=> (tone_ff != $past(tone_ff)))
    else $error("tone did not toggle on overflow");

  chk_tone_pin: assert property (
    tone_mode |-> (shared_output_pin_oe_o && shared_output_pin_o == tone_ff))
    else $error("tone not on shared pin");

  chk_mod_top: assert property (
    (ovf && !wr_count && pwm_mode) |=> (count_ff == 8'h00))
    else $error("pwm counter did not wrap to zero");

  chk_pwm_compare: assert property (
    ($past(mode_ff.timer_run && pwm_mode) && mode_ff.timer_run && pwm_mode && !$past(wr_count))
      |-> (pwm_ff == ((count_ff & cnt_mask) < (ref_active_ff & cnt_mask))))
    else $error("pwm level disagrees with compare");

  chk_zero_low: assert property (
    (ref_active_ff == 8'h00 && ref_stage_ff == 8'h00)[*3] |-> !pwm_ff)
    else $error("zero reference did not hold pwm low");

  chk_ref_hold: assert property (
    !ovf |=> $stable(ref_active_ff))
    else $error("active reference moved without overflow");

  chk_stop_quiet: assert property (
    !mode_ff.timer_run |=> (!tone_ff && !pwm_ff && $stable(count_ff) || $past(wr_count)))
    else $error("output or counter active while stopped");

  chk_flag_set: assert property (
    ovf |=> tick_irq_flag_o)
    else $error("overflow did not raise the flag");

  chk_reload_load: assert property (
    (ovf && !pwm_mode && mode_ff.reload_enable && !wr_count) |=> (count_ff == ref_active_ff))
    else $error("reload value not copied at overflow");

  cov_tone_ovf:  cover property (tone_mode && ovf);
  cov_pwm_16:    cover property (pwm_mode && cnt_mask == tpt_pkg::TPT_MASK_16 && ovf);
  cov_ref_swap:  cover property (pwm_mode && wr_reload ##[1:300] ovf);
  cov_ext_event: cover property (mode_ff.clock_source_select && tick);
endmodule : tpt_timer

// *** core/tpt_pkg.sv ***
package tpt_pkg;

  // ----------------------------------------------------------------
  // Register map (byte offsets on the 8-bit register port)
  // ----------------------------------------------------------------
  localparam logic [7:0] TPT_OFS_MODE   = 8'hDA;  // timer_mode_reg
  localparam logic [7:0] TPT_OFS_COUNT  = 8'hDB;  // count_value
  localparam logic [7:0] TPT_OFS_RELOAD = 8'hCD;  // reload_value, write only
  localparam logic [7:0] TPT_OFS_IRQ    = 8'hC0;  // tick_irq_enable / tick_irq_flag

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int         TPT_IRQ_EN_BIT   = 0;
  localparam int         TPT_IRQ_FLAG_BIT = 1;
  localparam logic [7:0] TPT_MODE_RST     = 8'h00;
  localparam logic [7:0] TPT_COUNT_RST    = 8'h00;
  localparam logic [7:0] TPT_RELOAD_RST   = 8'h00;
  localparam logic [7:0] TPT_RDATA_NONE   = 8'h00;

  // ----------------------------------------------------------------
  // Counter moduli as top-count masks
  // ----------------------------------------------------------------
  localparam logic [7:0] TPT_MASK_256 = 8'hFF;
  localparam logic [7:0] TPT_MASK_64  = 8'h3F;
  localparam logic [7:0] TPT_MASK_32  = 8'h1F;
  localparam logic [7:0] TPT_MASK_16  = 8'h0F;

  // Mode register, bit 7 down to bit 0
  typedef struct packed {
    logic       timer_run;
    logic [2:0] prescale_select;
    logic       clock_source_select;
    logic       reload_enable;
    logic       tone_out_enable;
    logic       pwm_out_enable;
  } tpt_mode_t;

  // One register port request
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } tpt_req_t;

endpackage : tpt_pkg

// *** verification/tpt_load.sv ***
`timescale 1ns/1ps

module tpt_load (
  // Clock
  input  wire logic        clk_sys_i,
  // Shared pin as the block drives it
  input  wire logic        pin_i,
  input  wire logic        pin_oe_i,
  // Measurements of the last complete period, and the number of rising edges seen
  output logic      [15:0] last_period_o,
  output logic      [15:0] last_high_o,
  output logic      [15:0] n_period_o
);
  logic        level;
  logic        level_ff;
  logic [15:0] cyc_ff;
  logic [15:0] hi_ff;

  // ---------------------------------------------------------------
  // Load side of the pin
  // ---------------------------------------------------------------
  // Pull-down in the load: a released pin reads low, never the last value
  assign level = pin_oe_i ? pin_i : 1'b0;

  initial begin
    level_ff      = 1'b0;
    cyc_ff        = 16'h0000;
    hi_ff         = 16'h0000;
    last_period_o = 16'h0000;
    last_high_o   = 16'h0000;
    n_period_o    = 16'h0000;
  end

  // Rising edge to rising edge; the first period after a change is partial
  always @(posedge clk_sys_i) begin
    level_ff <= level;
    if (level === 1'b1 && level_ff === 1'b0) begin
      last_period_o <= cyc_ff;
      last_high_o   <= hi_ff;
      n_period_o    <= n_period_o + 16'h0001;
      cyc_ff        <= 16'h0001;
      hi_ff         <= 16'h0001;
    end else begin
      cyc_ff <= cyc_ff + 16'h0001;
      hi_ff  <= hi_ff + {15'h0000, level === 1'b1};
    end
  end
endmodule : tpt_load

// *** verification/tb_top.sv ***
`timescale 1ns/1ps

module tb_top;
  // ---------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------
  logic                clk_sys   = 1'b0;
  logic                rst_n     = 1'b0;
  tpt_pkg::tpt_req_t   req       = '0;
  logic                ext_event = 1'b0;
  logic                gpio_out  = 1'b0;
  logic                gpio_oe   = 1'b0;
  logic          [7:0] rdata;
  logic                pin;
  logic                pin_oe;
  logic                takeover;
  logic                irq;
  logic                irq_flag;
  logic         [15:0] last_period;
  logic         [15:0] last_high;
  logic         [15:0] n_period;
  int                  bad_count = 0;
  int                  n_checks  = 0;
  logic         [15:0] mods [4]  = '{16'h0100, 16'h0040, 16'h0020, 16'h0010};
  logic          [7:0] refs [4]  = '{8'h01, 8'h3F, 8'h10, 8'h0F};

  // 200 MHz system clock
  always #2.5 clk_sys = ~clk_sys;

  tpt_timer i_tpt_timer (
    .clk_sys_i              (clk_sys),
    .rst_n_i                (rst_n),
    .addr_i                 (req.addr),
    .wdata_i                (req.wdata),
    .wr_i                   (req.wr),
    .rd_i                   (req.rd),
    .rdata_o                (rdata),
    .ext_event_i            (ext_event),
    .gpio_out_i             (gpio_out),
    .gpio_oe_i              (gpio_oe),
    .shared_output_pin_o    (pin),
    .shared_output_pin_oe_o (pin_oe),
    .pin_takeover_o         (takeover),
    .tick_irq_flag_o        (irq_flag),
    .tick_irq_o             (irq)
  );

  tpt_load i_tpt_load (
    .clk_sys_i     (clk_sys),
    .pin_i         (pin),
    .pin_oe_i      (pin_oe),
    .last_period_o (last_period),
    .last_high_o   (last_high),
    .n_period_o    (n_period)
  );

  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic stop_test;
    if (bad_count == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : stop_test

  task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_reg

  task automatic chk_wave(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_wave

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys);
    req.wr <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe edge
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys);
    req.rd <= 1'b0;
    #1;
    chk_reg(rdata, exp);
  endtask : rd

  // Stop first, clear the flag, then load values and start
  task automatic cfg(input logic [7:0] mode, input logic [7:0] cnt, input logic [7:0] refv);
    wr(tpt_pkg::TPT_OFS_MODE, 8'h00);
    wr(tpt_pkg::TPT_OFS_IRQ, 8'h00);
    wr(tpt_pkg::TPT_OFS_COUNT, cnt);
    wr(tpt_pkg::TPT_OFS_RELOAD, refv);
    wr(tpt_pkg::TPT_OFS_MODE, mode);
  endtask : cfg

  task automatic wait_per(input int n);
    int target;
    int guard;
    target = n_period + n;
    guard = 0;
    while (n_period < target && guard < 5000) begin
      @(posedge clk_sys);
      #1;
      guard++;
    end
    if (guard >= 5000) begin
      bad_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, n_period, target);
    end
  endtask : wait_per

  task automatic ev(input int n);
    repeat (n) begin
      @(posedge clk_sys);
      ext_event <= 1'b1;
      @(posedge clk_sys);
      ext_event <= 1'b0;
    end
    repeat (2) @(posedge clk_sys);
  endtask : ev

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (20) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    rd(tpt_pkg::TPT_OFS_MODE, tpt_pkg::TPT_MODE_RST);
    rd(tpt_pkg::TPT_OFS_COUNT, tpt_pkg::TPT_COUNT_RST);
    // Pin idle: general I/O owns it, so both levels must pass through
    @(posedge clk_sys);
    gpio_out <= 1'b1;
    gpio_oe  <= 1'b1;
    @(posedge clk_sys);
    #1;
    chk_wave({13'h0000, takeover, pin_oe, pin}, 16'h0003);
    @(posedge clk_sys);
    gpio_out <= 1'b0;
    gpio_oe  <= 1'b0;
    @(posedge clk_sys);
    #1;
    chk_wave({13'h0000, takeover, pin_oe, pin}, 16'h0000);
    wr(tpt_pkg::TPT_OFS_MODE, 8'h7E);
    rd(tpt_pkg::TPT_OFS_MODE, 8'h7E);
    wr(tpt_pkg::TPT_OFS_RELOAD, 8'hA5);
    rd(tpt_pkg::TPT_OFS_RELOAD, 8'h00);
    wr(8'h55, 8'hFF);
    rd(8'h55, 8'h00);
    // Tone at every rate; reload of 0xFF overflows on each tick
    for (int r = 0; r < 8; r++) begin
      cfg({1'b1, r[2:0], 4'b0110}, 8'hFF, 8'hFF);
      wait_per(3);
      chk_wave(last_period, 16'h0200 >> r);
      chk_wave(last_high, 16'h0100 >> r);
      chk_wave({14'h0000, takeover, pin_oe}, 16'h0003);
      rd(tpt_pkg::TPT_OFS_IRQ, 8'h02);
    end
    // Every PWM modulus, rate 111 gives a tick each second cycle
    for (int m = 0; m < 4; m++) begin
      cfg(8'hF1 | {5'h00, m[1:0], 1'b0}, 8'h00, refs[m]);
      wait_per(3);
      chk_wave(last_period, mods[m] << 1);
      chk_wave(last_high, {7'h00, refs[m], 1'b0});
      chk_wave({14'h0000, takeover, pin_oe}, 16'h0003);
      rd(tpt_pkg::TPT_OFS_IRQ, 8'h02);
    end
    // New reference written early in the high phase
    cfg(8'hF7, 8'h00, 8'h04);
    wait_per(3);
    chk_wave(last_high, 16'h0008);
    wr(tpt_pkg::TPT_OFS_RELOAD, 8'h01);
    wait_per(1);
    chk_wave(last_high, 16'h0008);
    wait_per(1);
    chk_wave(last_high, 16'h0002);
    chk_wave(last_period, 16'h0020);
    // Run cleared while the output is high
    wr(tpt_pkg::TPT_OFS_RELOAD, 8'h0F);
    wait_per(2);
    wr(tpt_pkg::TPT_OFS_MODE, 8'h77);
    @(posedge clk_sys);
    #1;
    chk_wave({15'h0000, pin}, 16'h0000);
    wr(tpt_pkg::TPT_OFS_COUNT, 8'h05);
    repeat (20) @(posedge clk_sys);
    rd(tpt_pkg::TPT_OFS_COUNT, 8'h05);
    // Zero reference keeps the output low
    cfg(8'hF7, 8'h00, 8'h00);
    repeat (80) @(posedge clk_sys);
    repeat (32) begin
      @(posedge clk_sys);
      #1;
      chk_wave({15'h0000, pin}, 16'h0000);
    end
    // External events; the fast rate field must have no effect
    cfg(8'hF8, 8'hFD, 8'h00);
    wr(tpt_pkg::TPT_OFS_IRQ, 8'h01);
    ev(2);
    rd(tpt_pkg::TPT_OFS_COUNT, 8'hFF);
    chk_wave({14'h0000, irq_flag, irq}, 16'h0000);
    ev(1);
    rd(tpt_pkg::TPT_OFS_COUNT, 8'h00);
    chk_wave({14'h0000, irq_flag, irq}, 16'h0003);
    rd(tpt_pkg::TPT_OFS_IRQ, 8'h03);
    stop_test;
  end

  // Watchdog well beyond the expected run of about 4700 cycles
  initial begin
    repeat (30000) @(posedge clk_sys);
    bad_count++;
    stop_test;
  end
endmodule : tb_top
